// ### dbg_defines.svh
// constants for the debug unlock handshake and reset request block
`ifndef DBG_DEFINES_SVH
`define DBG_DEFINES_SVH
// link frame layout: op bit, target bit, then 32 data bits msb first
`define LINK_HDR_BITS     6'h02
`define LINK_LAST_BIT     6'h21
`define LINK_FRAME_BITS   6'h22
`define LINK_OP_WRITE     1'b1
`define TGT_COMM_DATA     1'b0
`define TGT_TOOL_CONFIG   1'b1
// field position of the reset request field in the tool config register
`define RST_REQ_BIT       7
// startup values and command codes
`define COMM_RESET_VAL    32'h0000_0000
`define COMM_CONSUMED     32'h0000_0000
`define KEY_EXCHANGE_CMD  32'h4b45_5943
`define PASSWORD_WORDS    4'h8
// firmware sampling window, in ns, and its length in clock cycles
`define REF_CLK_NS        25
`define WINDOW_NS         50000
`define WINDOW_CYCLES     ((`WINDOW_NS + `REF_CLK_NS - 1) / `REF_CLK_NS)
// spacing between two password words taken from the buffer
`define POP_GAP_CYCLES    8'h10
`endif

// ### dbg_pkg.sv
// types shared by the debug unlock handshake block
package dbg_pkg;
    typedef enum logic [2:0]
    {
        FW_BIST     = 3'h0,
        FW_POST     = 3'h1,
        FW_WAIT     = 3'h2,
        FW_SAMPLE   = 3'h3,
        FW_PASSWORD = 3'h4,
        FW_UNLOCKED = 3'h5,
        FW_LOCKED   = 3'h6
    } fw_state_t;
endpackage

// ### debug_unlock.sv
// debug link slave with startup key exchange and reset request
`timescale 1ns/1ps
`include "dbg_defines.svh"

////////////////////////////////////////////////////////////////////////
// small synchronous fifo with valid and ready on both sides
module dbg_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input  wire logic             ref_clk,    // block clock
    input  wire logic             rst,        // sync reset, high
    input  wire logic             in_valid,   // word offered
    output logic                  in_ready,   // room for a word
    input  wire logic [WIDTH-1:0] in_data,    // word in
    output logic                  out_valid,  // word available
    input  wire logic             out_ready,  // consumer takes word
    output logic      [WIDTH-1:0] out_data    // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             push;
    logic             pop;

    // extra pointer bit tells full from empty
    always_comb
    begin
        in_ready  = (wr_ptr[AW] == rd_ptr[AW])
                  || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
        out_valid = (wr_ptr != rd_ptr);
        out_data  = mem[rd_ptr[AW-1:0]];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
        if (push)
            mem[wr_ptr[AW-1:0]] <= in_data;
    end
endmodule

////////////////////////////////////////////////////////////////////////
// top: link slave, startup firmware sequencer, reset request
module debug_unlock #(
    parameter logic [31:0]  DEVICE_ID     = 32'h1234_5678, // arbitrary
    parameter logic [255:0] PASSWORD      = '0,
    parameter int           WINDOW_CYCLES = `WINDOW_CYCLES,
    parameter int           FIFO_DEPTH    = 4
) (
    input  wire logic ref_clk,       // 40 mhz block clock
    input  wire logic rst,           // power-on reset, sync, high
    input  wire logic link_clk,      // tool link clock, async
    input  wire logic link_frame,    // high during a frame, async
    input  wire logic link_mosi,     // tool to device data, async
    input  wire logic bist_busy,     // self test running, async
    output logic      link_miso,     // device to tool data
    output logic      link_miso_oe,  // high while miso is driven
    output logic      app_reset_req, // application reset request
    output logic      unlocked,      // password accepted
    output logic      window_open,   // key command would be seen
    output logic      pw_full        // password buffer refusing
);
    // two-stage synchronisers plus one stage for edge finding
    logic [2:0] clk_s;
    logic [1:0] frame_s;
    logic [1:0] mosi_s;
    logic [1:0] bist_s;

    always_ff @(posedge ref_clk)
    begin
        clk_s   <= {clk_s[1:0], link_clk};
        frame_s <= {frame_s[0], link_frame};
        mosi_s  <= {mosi_s[0], link_mosi};
        bist_s  <= {bist_s[0], bist_busy};
    end

    logic clk_rise;
    logic clk_fall;
    assign clk_rise = clk_s[1] && !clk_s[2];
    assign clk_fall = !clk_s[1] && clk_s[2];

    ////////////////////////////////////////////////////////////////////
    // link frame decoder
    logic [5:0]  bit_cnt;
    logic [1:0]  hdr;
    logic [31:0] in_sr;
    logic [31:0] out_sr;
    logic        wr_comm;
    logic        wr_cfg;
    logic [31:0] wr_data;
    logic [31:0] comm_data;
    logic [5:0]  next_bit_cnt;
    logic [1:0]  next_hdr;
    logic [31:0] next_in_sr;
    logic [31:0] next_out_sr;
    logic        next_wr_comm;
    logic        next_wr_cfg;
    logic [31:0] next_wr_data;
    logic        next_miso;
    logic        next_miso_oe;

    // a frame cut short never writes; rising edges sample the tool
    always_comb
    begin
        next_bit_cnt = bit_cnt;
        next_hdr     = hdr;
        next_in_sr   = in_sr;
        next_out_sr  = out_sr;
        next_wr_comm = 1'b0;
        next_wr_cfg  = 1'b0;
        next_wr_data = wr_data;
        next_miso    = link_miso;
        next_miso_oe = link_miso_oe;
        if (bist_s[1] || !frame_s[1])
        begin
            next_bit_cnt = '0;
            next_miso_oe = 1'b0;
            next_miso    = 1'b0;
        end
        else if (clk_rise && bit_cnt < `LINK_FRAME_BITS)
        begin
            next_bit_cnt = bit_cnt + 6'h01;
            if (bit_cnt < `LINK_HDR_BITS)
                next_hdr = {hdr[0], mosi_s[1]};
            else
                next_in_sr = {in_sr[30:0], mosi_s[1]};
            // read: snapshot comm data once the header is in
            if (bit_cnt == `LINK_HDR_BITS - 6'h01
                && hdr[0] != `LINK_OP_WRITE)
            begin
                next_out_sr  = comm_data;
                next_miso_oe = 1'b1;
            end
            if (bit_cnt == `LINK_LAST_BIT && hdr[1] == `LINK_OP_WRITE)
            begin
                next_wr_data = {in_sr[30:0], mosi_s[1]};
                next_wr_comm = (hdr[0] == `TGT_COMM_DATA);
                next_wr_cfg  = (hdr[0] == `TGT_TOOL_CONFIG);
            end
        end
        else if (clk_fall && link_miso_oe)
        begin
            // change on falling edge so tool samples on rising edge
            next_miso   = out_sr[31];
            next_out_sr = {out_sr[30:0], 1'b0};
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            bit_cnt      <= '0;
            hdr          <= '0;
            in_sr        <= '0;
            out_sr       <= '0;
            wr_comm      <= 1'b0;
            wr_cfg       <= 1'b0;
            wr_data      <= '0;
            link_miso    <= 1'b0;
            link_miso_oe <= 1'b0;
        end
        else
        begin
            bit_cnt      <= next_bit_cnt;
            hdr          <= next_hdr;
            in_sr        <= next_in_sr;
            out_sr       <= next_out_sr;
            wr_comm      <= next_wr_comm;
            wr_cfg       <= next_wr_cfg;
            wr_data      <= next_wr_data;
            link_miso    <= next_miso;
            link_miso_oe <= next_miso_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // password buffer between link and firmware
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic [31:0] fifo_out_data;
    logic        pw_push;

    dbg_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) pw_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (pw_push),
        .in_ready  (fifo_in_ready),
        .in_data   (wr_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////
    // startup firmware sequencer and tool config
    dbg_pkg::fw_state_t state;
    dbg_pkg::fw_state_t next_state;
    logic [31:0] wait_cnt;
    logic [3:0]  pw_cnt;
    logic [7:0]  gap_cnt;
    logic        mismatch;
    logic [31:0] next_wait_cnt;
    logic [3:0]  next_pw_cnt;
    logic [7:0]  next_gap_cnt;
    logic        next_mismatch;
    logic [31:0] next_comm_data;
    logic        next_app_reset_req;
    logic        next_unlocked;
    logic        next_window_open;
    logic        next_pw_full;

    // password words go to the buffer only while it is being drained
    assign pw_push        = wr_comm && (state == dbg_pkg::FW_PASSWORD);
    // drain is paced so a fast tool can fill the buffer
    assign fifo_out_ready = (state == dbg_pkg::FW_PASSWORD)
                          && (gap_cnt == 8'h00);

    always_comb
    begin
        next_state         = state;
        next_wait_cnt      = wait_cnt;
        next_pw_cnt        = pw_cnt;
        next_gap_cnt       = (gap_cnt != 8'h00) ? gap_cnt - 8'h01 : gap_cnt;
        next_mismatch      = mismatch;
        next_unlocked      = unlocked;
        next_comm_data     = wr_comm ? wr_data : comm_data;
        next_app_reset_req = app_reset_req;
        next_pw_full       = wr_comm && (state == dbg_pkg::FW_PASSWORD)
                           && !fifo_in_ready;
        // request follows the field on every write, set or clear
        if (wr_cfg)
            next_app_reset_req = wr_data[`RST_REQ_BIT];
        case (state)
            dbg_pkg::FW_BIST:
                if (!bist_s[1])
                    next_state = dbg_pkg::FW_POST;
            dbg_pkg::FW_POST:
            begin
                // overwrite wins: an early key command is lost here
                next_comm_data = DEVICE_ID;
                next_wait_cnt  = '0;
                next_state     = dbg_pkg::FW_WAIT;
            end
            dbg_pkg::FW_WAIT:
            begin
                next_wait_cnt = wait_cnt + 32'h1;
                if (wait_cnt == 32'(WINDOW_CYCLES - 1))
                    next_state = dbg_pkg::FW_SAMPLE;
            end
            dbg_pkg::FW_SAMPLE:
                if (comm_data == `KEY_EXCHANGE_CMD)
                begin
                    next_pw_cnt   = '0;
                    next_mismatch = 1'b0;
                    next_state    = dbg_pkg::FW_PASSWORD;
                end
                else
                begin
                    next_comm_data = DEVICE_ID;
                    next_state     = dbg_pkg::FW_LOCKED;
                end
            dbg_pkg::FW_PASSWORD:
                if (fifo_out_valid && fifo_out_ready)
                begin
                    // compare word, then mark it consumed for the tool
                    if (fifo_out_data != PASSWORD[255 - 32*pw_cnt[2:0] -: 32])
                        next_mismatch = 1'b1;
                    next_comm_data = wr_comm ? wr_data : `COMM_CONSUMED;
                    next_gap_cnt   = `POP_GAP_CYCLES;
                    next_pw_cnt    = pw_cnt + 4'h1;
                    if (pw_cnt == `PASSWORD_WORDS - 4'h1)
                    begin
                        next_unlocked = !(mismatch || fifo_out_data
                            != PASSWORD[255 - 32*pw_cnt[2:0] -: 32]);
                        next_state = next_unlocked ? dbg_pkg::FW_UNLOCKED
                                                   : dbg_pkg::FW_LOCKED;
                    end
                end
            dbg_pkg::FW_UNLOCKED:
                next_state = state;
            dbg_pkg::FW_LOCKED:
                next_state = state;
            default:
                next_state = dbg_pkg::FW_LOCKED;
        endcase
        next_window_open = (next_state == dbg_pkg::FW_WAIT);
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state         <= dbg_pkg::FW_BIST;
            wait_cnt      <= '0;
            pw_cnt        <= '0;
            gap_cnt       <= '0;
            mismatch      <= 1'b0;
            comm_data     <= `COMM_RESET_VAL;
            app_reset_req <= 1'b0;
            unlocked      <= 1'b0;
            window_open   <= 1'b0;
            pw_full       <= 1'b0;
        end
        else
        begin
            state         <= next_state;
            wait_cnt      <= next_wait_cnt;
            pw_cnt        <= next_pw_cnt;
            gap_cnt       <= next_gap_cnt;
            mismatch      <= next_mismatch;
            comm_data     <= next_comm_data;
            app_reset_req <= next_app_reset_req;
            unlocked      <= next_unlocked;
            window_open   <= next_window_open;
            pw_full       <= next_pw_full;
        end
    end
endmodule

// ### debug_unlock_properties.sv
// port assertions for the debug unlock block
`timescale 1ns/1ps
module debug_unlock_chk #(
    parameter int WINDOW_CYCLES = 2000
) (
    input wire logic ref_clk,       // block clock
    input wire logic rst,           // sync reset, high
    input wire logic link_clk,      // link clock
    input wire logic link_frame,    // frame marker
    input wire logic link_mosi,     // tool data
    input wire logic bist_busy,     // self test running
    input wire logic link_miso,     // device data
    input wire logic link_miso_oe,  // miso driven
    input wire logic app_reset_req, // reset request
    input wire logic unlocked,      // password accepted
    input wire logic window_open,   // key window
    input wire logic pw_full        // buffer refusing
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////
    // window length, and time since the firmware took its sample
    logic [15:0] win_cnt;
    logic [15:0] next_win_cnt;
    logic [15:0] since;
    logic [15:0] next_since;
    logic        win_done;
    logic        next_win_done;
    logic        win_q;
    always_comb
    begin
        next_win_cnt  = window_open ? win_cnt + 16'h0001 : 16'h0000;
        next_win_done = win_done | (win_q & ~window_open);
        next_since    = since;
        if (win_done && since != 16'hffff)
            next_since = since + 16'h0001; // saturates, no wrap
        if (rst)
        begin
            next_win_cnt  = 16'h0000;
            next_win_done = 1'b0;
            next_since    = 16'h0000;
        end
    end
    always_ff @(posedge ref_clk)
    begin
        win_cnt  <= next_win_cnt;
        win_done <= next_win_done;
        since    <= next_since;
        win_q    <= window_open & ~rst;
    end

    ////////////////////////////////////////////////////////////////////
    // output rules; unlock lies at least 1900 cycles after the sample
    property p_quiet_reset;
        $fell(rst) |-> !window_open && !unlocked && !app_reset_req
                       && !link_miso_oe;
    endproperty
    a_quiet_reset: assert property (p_quiet_reset)
        else $error("outputs not idle after reset");
    property p_bist_silent;
        bist_busy [*4] |-> !link_miso_oe && !window_open;
    endproperty
    a_bist_silent: assert property (p_bist_silent)
        else $error("link answered during self test");
    property p_oe_frame;
        (!link_frame) [*8] |-> !link_miso_oe;
    endproperty
    a_oe_frame: assert property (p_oe_frame)
        else $error("miso driven outside a frame");
    property p_win_bound;
        win_cnt <= WINDOW_CYCLES + 4;
    endproperty
    a_win_bound: assert property (p_win_bound)
        else $error("key window never sampled");
    property p_win_once;
        win_done |-> !window_open;
    endproperty
    a_win_once: assert property (p_win_once)
        else $error("key window reopened");
    property p_unlock_late;
        $rose(unlocked) |-> win_done && since >= 16'h076c;
    endproperty
    a_unlock_late: assert property (p_unlock_late)
        else $error("unlock without eight words after sample");
    property p_unlock_hold;
        unlocked |=> unlocked;
    endproperty
    a_unlock_hold: assert property (p_unlock_hold)
        else $error("unlock dropped");
    property p_req_stable;
        (!link_frame) [*8] |=> $stable(app_reset_req);
    endproperty
    a_req_stable: assert property (p_req_stable)
        else $error("reset request moved without a write");
    c_unlock: cover property ($rose(unlocked));
    c_sample: cover property ($fell(window_open));
    c_release: cover property ($fell(app_reset_req));
    c_answer: cover property ($rose(link_miso_oe));
endmodule

bind debug_unlock debug_unlock_chk #(.WINDOW_CYCLES(WINDOW_CYCLES)) chk_u (
    .ref_clk(ref_clk), .rst(rst), .link_clk(link_clk),
    .link_frame(link_frame), .link_mosi(link_mosi), .bist_busy(bist_busy),
    .link_miso(link_miso), .link_miso_oe(link_miso_oe),
    .app_reset_req(app_reset_req), .unlocked(unlocked),
    .window_open(window_open), .pw_full(pw_full));

// ### debug_tool_model.sv
// model of the external debug tool on the link
`timescale 1ns/1ps
`include "dbg_defines.svh"
module debug_tool (
    input  wire logic ref_clk,      // paces the link
    input  wire logic link_miso,    // device data
    input  wire logic link_miso_oe, // device drives miso
    output logic      link_clk,     // still low between frames
    output logic      link_frame,   // frame marker
    output logic      link_mosi     // tool data
);
    logic [31:0] d;
    logic        oe;
    initial
    begin
        link_clk = 1'b0;
        link_frame = 1'b0;
        link_mosi = 1'b0;
    end
    // half a 200 ns link period
    task automatic half();
        repeat (4) @(negedge ref_clk);
    endtask
    // one frame; read bits taken late in the high phase, once settled
    task automatic xfer(input logic op, input logic tgt,
        input logic [31:0] wd, output logic [31:0] rd, output logic ans);
        logic [33:0] bits;
        bits = {op, tgt, wd};
        rd = 32'h0000_0000;
        ans = 1'b0;
        link_frame = 1'b1;
        for (int i = 0; i < 34; i++)
        begin
            link_mosi = bits[33-i];
            half();
            link_clk = 1'b1;
            half();
            if (i > 1)
            begin
                rd = {rd[30:0], link_miso_oe ? link_miso : ~rd[0]};
                ans |= link_miso_oe;
            end
            link_clk = 1'b0;
        end
        half();
        link_frame = 1'b0;
        link_mosi = ~link_mosi; // released line shows no stale bit
        repeat (4) half();
    endtask
    task automatic wr(input logic tgt, input logic [31:0] wd);
        xfer(1'b1, tgt, wd, d, oe);
    endtask
    task automatic rd_word(output logic [31:0] rd, output logic ans);
        xfer(1'b0, 1'b0, 32'h0000_0000, rd, ans);
    endtask
    // poll for the identifier, then send the key at once
    task automatic open_key(input logic [31:0] id, output logic found);
        found = 1'b0;
        for (int t = 0; t < 8 && !found; t++)
        begin
            rd_word(d, oe);
            found = (d === id);
        end
        if (found)
            wr(1'b0, `KEY_EXCHANGE_CMD);
    endtask
    // one word at a time, each polled up to three reads for consumption
    task automatic send_pw(input logic [255:0] pw, input int n);
        for (int k = 0; k < n; k++)
        begin
            wr(1'b0, pw[255-32*k -: 32]);
            for (int t = 0; t < 3 && d !== 32'h0000_0000; t++)
                rd_word(d, oe);
        end
    endtask
    // double release write, as a careful tool does
    task automatic release_req();
        wr(1'b1, 32'h0000_0000);
        wr(1'b1, 32'h0000_0000);
    endtask
endmodule

// ### debug_unlock_tb.sv
// self-checking bench for the debug unlock block
`timescale 1ns/1ps
`include "dbg_defines.svh"
module debug_unlock_tb;
    localparam logic [31:0]  DEV_ID = 32'h5a3c_0f96; // arbitrary
    localparam logic [255:0] PW = {
        128'h1111_2222_3333_4444_5555_6666_7777_8888,
        128'h9999_aaaa_bbbb_cccc_dddd_eeee_f0f0_0f0f};
    localparam int           WIN = 1200;
    logic        ref_clk, rst, bist_busy, link_clk, link_frame, link_mosi;
    logic        link_miso, link_miso_oe, app_reset_req, unlocked;
    logic        window_open, pw_full, oe, found;
    logic [31:0] rd;
    int          err_count, n_compared;

    debug_unlock #(.DEVICE_ID(DEV_ID), .PASSWORD(PW),
        .WINDOW_CYCLES(WIN), .FIFO_DEPTH(4)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .link_clk(link_clk),
        .link_frame(link_frame), .link_mosi(link_mosi),
        .bist_busy(bist_busy), .link_miso(link_miso),
        .link_miso_oe(link_miso_oe), .app_reset_req(app_reset_req),
        .unlocked(unlocked), .window_open(window_open), .pw_full(pw_full));
    debug_tool tool_u (.ref_clk(ref_clk), .link_miso(link_miso),
        .link_miso_oe(link_miso_oe), .link_clk(link_clk),
        .link_frame(link_frame), .link_mosi(link_mosi));

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
        input string msg);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // power-on with self test running; a read then must go unanswered
    task automatic power_on();
        rst = 1'b1;
        bist_busy = 1'b1;
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        tool_u.rd_word(rd, oe);
        check(oe, 1'b0, "answer during self test");
        bist_busy = 1'b0;
    endtask
    // exactly the eighth good word unlocks
    task automatic t_unlock_ok();
        power_on();
        tool_u.open_key(DEV_ID, found);
        check(found, 1'b1, "identifier not posted");
        // a word written before the sample would overwrite the key
        repeat (WIN) @(negedge ref_clk);
        tool_u.send_pw(PW, 7);
        check(unlocked, 1'b0, "unlocked after seven words");
        tool_u.wr(1'b0, PW[31:0]);
        repeat (40) @(negedge ref_clk);
        check(unlocked, 1'b1, "not unlocked after eight");
        check(pw_full, 1'b0, "paced words refused");
    endtask
    // one flipped bit in the last word keeps the lock
    task automatic t_unlock_bad();
        power_on();
        tool_u.open_key(DEV_ID, found);
        check(found, 1'b1, "identifier not posted again");
        repeat (WIN) @(negedge ref_clk);
        tool_u.send_pw(PW ^ 256'h1, 8);
        repeat (40) @(negedge ref_clk);
        check(unlocked, 1'b0, "wrong password accepted");
    endtask
    // other word in the window: identifier reposted; late key lost
    task automatic t_late_key();
        power_on();
        tool_u.wr(1'b0, 32'h0000_0001);
        repeat (WIN) @(negedge ref_clk);
        tool_u.rd_word(rd, oe);
        check(rd, DEV_ID, "identifier not reposted");
        tool_u.wr(1'b0, `KEY_EXCHANGE_CMD);
        tool_u.send_pw(PW, 8);
        check(unlocked, 1'b0, "late key unlocked");
        check(window_open, 1'b0, "window open after sample");
    endtask
    // request follows bit 7 only; a single clear already releases
    task automatic t_reset_req();
        tool_u.wr(1'b1, 32'h0000_0080);
        check(app_reset_req, 1'b1, "request not raised");
        repeat (200) @(negedge ref_clk);
        check(app_reset_req, 1'b1, "request not held");
        tool_u.wr(1'b1, 32'hffff_ff7f);
        check(app_reset_req, 1'b0, "first release failed");
        tool_u.wr(1'b1, 32'h0000_0080);
        tool_u.release_req();
        check(app_reset_req, 1'b0, "double release failed");
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // hang guard, well beyond the expected run
    initial
    begin
        #1_500_000;
        err_count++;
        end_sim();
    end
    initial
    begin
        rst = 1'b1;
        bist_busy = 1'b1;
        err_count = 0;
        n_compared = 0;
        t_unlock_ok();
        t_unlock_bad();
        t_late_key();
        t_reset_req();
        end_sim();
    end
endmodule
